// [shared/miar_pkg.sv]
package miar_pkg;
  // register offsets on the internal register port
  localparam logic [6:0] OFS_INT_STATUS  = 7'h4A;
  localparam logic [6:0] OFS_PIN_AXIS    = 7'h4E;
  localparam logic [6:0] OFS_LOW_LIMIT   = 7'h4F;
  localparam logic [6:0] OFS_HIGH_LIMIT  = 7'h50;
  localparam logic [6:0] OFS_XY_REPEAT   = 7'h51;
  localparam logic [6:0] OFS_Z_REPEAT    = 7'h52;

  // field positions in pin_map_and_axis_enable
  localparam int BIT_READY_PIN_EN  = 7;
  localparam int BIT_INT_PIN_EN    = 6;
  localparam int BIT_Z_OFF         = 5;
  localparam int BIT_Y_OFF         = 4;
  localparam int BIT_X_OFF         = 3;
  localparam int BIT_READY_LEVEL   = 2;
  localparam int BIT_INT_LATCH     = 1;
  localparam int BIT_INT_LEVEL     = 0;

  // reset values
  localparam logic [7:0] RST_PIN_AXIS   = 8'h07;
  localparam logic [7:0] RST_LOW_LIMIT  = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT = 8'h00;
  localparam logic [7:0] RST_XY_REPEAT  = 8'h00;
  localparam logic [7:0] RST_Z_REPEAT   = 8'h00;

  // measurement word and repetition count widths
  localparam int SAMPLE_W = 16;
  localparam int COUNT_W  = 9;
endpackage

// [testbench/miar_config_test.sv]
`timescale 1ns/10ps
module miar_config_test;
  import miar_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rv = 1'b0, rdy = 1'b0, oth = 1'b0, wr, rd, res_on, pin_r, pin_i;
  logic [6:0]  addr;
  logic [7:0]  wd, rdata, v, exp_q[$];
  logic [2:0]  sv = 3'h0, lo_en = 3'h0, hi_en = 3'h0, meas;
  logic [47:0] sd = 48'h0, axd, d1;
  logic [15:0] rdd = 16'h0, resd, r1;
  logic [8:0]  xyr, zr;
  integer      fail_count = 0, n_checks = 0, seed = 32'h6a28, i;
  miar_host host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wd_o(wd));
  miar_config uut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wd),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .SAMPLE_VALID_I(sv), .SAMPLE_DATA_I(sd), .RES_VALID_I(rv),
    .RES_DATA_I(rdd), .AXIS_MEASURE_O(meas), .RES_MEASURE_O(res_on), .XY_REPEAT_O(xyr), .Z_REPEAT_O(zr),
    .AXIS_DATA_O(axd), .RES_DATA_O(resd), .READY_STATUS_I(rdy), .LOW_AXIS_EN_I(lo_en),
    .HIGH_AXIS_EN_I(hi_en), .OTHER_INT_I(oth), .SAMPLE_READY_PIN_O(pin_r), .INT_PIN_O(pin_i));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task rdx(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.put(a, 8'h00, 1'b0);
  endtask
  task smp(input logic [47:0] d, input logic [15:0] r);
    @(negedge clk);
    {sv, sd, rv, rdd} = {3'h7, d, 1'b1, r};
    @(negedge clk);
    {sv, sd, rv, rdd} = {3'h0, ~d, 1'b0, ~r};
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read data is registered on the read edge and checked half a cycle later
  always @(posedge clk) begin
    if (rd === 1'b1) begin
      @(negedge clk);
      chk(64'(rdata), 64'(exp_q.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial begin
    cyc(10);
    rst = 1'b0;
    rdx(OFS_PIN_AXIS, RST_PIN_AXIS);
    for (i = 0; i < 4; i++) rdx(OFS_LOW_LIMIT + 7'(i), 8'h00);
    rdx(7'h53, 8'h00);
    chk({meas, res_on, xyr, zr, pin_r, pin_i}, {4'hF, 9'h001, 9'h001, 2'b00});
    $display("test 1 done");
    for (i = 0; i < 8; i++) begin
      v = (i < 4) ? 8'hFF : 8'($random(seed));
      host.put(OFS_LOW_LIMIT + 7'(i % 4), v, 1'b1);
      rdx(OFS_LOW_LIMIT + 7'(i % 4), v);
      if (i % 4 == 2) chk(xyr, 9'h001 + {v, 1'b0});
      if (i % 4 == 3) chk(zr, 9'h001 + 9'(v));
    end
    $display("test 2 done");
    d1 = {16'($random(seed)), 8'h7F, 8'($random(seed)), 8'h80, 8'($random(seed))};
    r1 = 16'($random(seed));
    smp(d1, r1);
    chk({axd, resd}, {d1, r1});
    host.put(OFS_PIN_AXIS, 8'h38, 1'b1);
    cyc(2);
    chk({meas, res_on, resd, pin_r, pin_i}, {4'h0, 16'h0000, 2'b11});
    smp({32'($random(seed)), 16'($random(seed))}, ~r1);
    chk({axd, resd}, {d1, 16'h0000});
    $display("test 3 done");
    host.put(OFS_LOW_LIMIT, 8'h7F, 1'b1);
    host.put(OFS_PIN_AXIS, 8'h7B, 1'b1);
    @(negedge clk);
    lo_en = 3'h1;
    @(negedge clk);
    lo_en = 3'h0;
    cyc(3);
    chk(pin_i, 1'b1);
    rdx(OFS_INT_STATUS, 8'h00);
    cyc(2);
    chk(pin_i, 1'b0);
    host.put(OFS_PIN_AXIS, 8'hFD, 1'b1);
    for (i = 0; i < 2; i++) begin
      @(negedge clk);
      {rdy, oth} = {2{~i[0]}};
      cyc(2);
      chk({pin_r, pin_i}, {2{~i[0]}});
    end
    $display("test 4 done");
    host.put(OFS_HIGH_LIMIT, 8'h7E, 1'b1);
    @(negedge clk);
    hi_en = 3'h2;
    cyc(2);
    chk(pin_i, 1'b1);
    host.put(OFS_HIGH_LIMIT, 8'h7F, 1'b1);
    cyc(2);
    chk(pin_i, 1'b0);
    hi_en = 3'h0;
    host.put(OFS_PIN_AXIS, 8'hC0, 1'b1);
    {rdy, oth} = 2'b11;
    cyc(2);
    chk({pin_r, pin_i}, 2'b00);
    {rdy, oth} = 2'b00;
    cyc(2);
    chk({pin_r, pin_i}, 2'b11);
    $display("test 5 done");
    complete_run;
  end
endmodule

// [testbench/miar_host.sv]
`timescale 1ns/10ps
module miar_host (
  // register port toward the block
  input  wire logic       clk_i,
  output logic      [6:0] addr_o = 7'h00,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0,
  output logic      [7:0] wd_o = 8'h00
);
  task put(input logic [6:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    addr_o = a;
    wd_o = d;
    wr_o = w;
    rd_o = ~w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // released address and data lines show the inverse of the last value; wr_o and rd_o return to 0
    addr_o = ~a;
    wd_o = ~d;
  endtask
endmodule

// [testbench/miar_properties.sv]
`timescale 1ns/10ps
module miar_properties
  import miar_pkg::*;
(
  // clock, reset and register port
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic [6:0]  REG_ADDR_I,
  input wire logic        REG_WR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        REG_RD_I,
  // measurement side and pins
  input wire logic [2:0]  SAMPLE_VALID_I,
  input wire logic [2:0]  AXIS_MEASURE_O,
  input wire logic        RES_MEASURE_O,
  input wire logic [8:0]  XY_REPEAT_O,
  input wire logic [8:0]  Z_REPEAT_O,
  input wire logic [47:0] AXIS_DATA_O,
  input wire logic [15:0] RES_DATA_O,
  input wire logic        READY_STATUS_I,
  input wire logic        SAMPLE_READY_PIN_O,
  input wire logic        INT_PIN_O
);
  logic       w4e, wxy, wz, rd4a;
  logic [7:0] cfg, next_cfg;
  assign w4e = REG_WR_I && REG_ADDR_I == OFS_PIN_AXIS;
  assign wxy = REG_WR_I && REG_ADDR_I == OFS_XY_REPEAT;
  assign wz = REG_WR_I && REG_ADDR_I == OFS_Z_REPEAT;
  assign rd4a = REG_RD_I && REG_ADDR_I == OFS_INT_STATUS;
  // mirror of the pin and axis register, rebuilt from the writes
  always_comb next_cfg = w4e ? REG_WDATA_I : cfg;
  always_ff @(posedge CLK_I) cfg <= RST_I ? RST_PIN_AXIS : next_cfg;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_RDY_PIN: assert property (!$past(w4e) |-> SAMPLE_READY_PIN_O == ((cfg[7] & $past(READY_STATUS_I)) ~^ cfg[2]))
    else $error("ready pin level wrong");
  AST_INT_OFF: assert property (!$past(w4e) && !cfg[6] |-> INT_PIN_O == !cfg[0])
    else $error("disabled interrupt pin not idle");
  AST_LATCH: assert property (!$past(w4e) && !w4e && !$past(rd4a) && cfg[6] && cfg[1] && cfg[0] && INT_PIN_O |=> INT_PIN_O)
    else $error("latched interrupt dropped");
  AST_MEASURE: assert property (!$past(w4e) |-> {RES_MEASURE_O, AXIS_MEASURE_O} == ~{cfg[5], cfg[5:3]})
    else $error("measure enables wrong");
  AST_RES_ZERO: assert property (!$past(w4e) && cfg[5] |-> RES_DATA_O == 16'h0000)
    else $error("resistance not zero");
  AST_HOLD_X: assert property (!$past(w4e) && cfg[3] |=> $stable(AXIS_DATA_O[15:0]))
    else $error("disabled x value changed");
  AST_XY_COUNT: assert property (wxy ##1 !wxy |=> XY_REPEAT_O == 9'h001 + {$past(REG_WDATA_I, 2), 1'b0})
    else $error("xy repeat count wrong");
  AST_Z_COUNT: assert property (wz ##1 !wz |=> Z_REPEAT_O == 9'h001 + $past(REG_WDATA_I, 2))
    else $error("z repeat count wrong");
  COV_LATCH: cover property (cfg[1] && INT_PIN_O && rd4a);
  COV_HOLD: cover property (cfg[3] && SAMPLE_VALID_I[0]);
  COV_LEVEL: cover property (!cfg[1] && cfg[6] && INT_PIN_O);
endmodule

bind miar_config miar_properties chk (.*);

// [verilog/miar_config.sv]
`timescale 1ns/10ps
module miar_config (
  // clock and reset
  input  wire logic                            CLK_I,
  input  wire logic                            RST_I,
  // register port from the serial interface
  input  wire logic [6:0]                      REG_ADDR_I,
  input  wire logic                            REG_WR_I,
  input  wire logic [7:0]                      REG_WDATA_I,
  input  wire logic                            REG_RD_I,
  output logic      [7:0]                      REG_RDATA_O,
  // measurement engine
  input  wire logic [2:0]                      SAMPLE_VALID_I,
  input  wire logic [3*miar_pkg::SAMPLE_W-1:0] SAMPLE_DATA_I,
  input  wire logic                            RES_VALID_I,
  input  wire logic [miar_pkg::SAMPLE_W-1:0]   RES_DATA_I,
  output logic      [2:0]                      AXIS_MEASURE_O,
  output logic                                 RES_MEASURE_O,
  output logic      [miar_pkg::COUNT_W-1:0]    XY_REPEAT_O,
  output logic      [miar_pkg::COUNT_W-1:0]    Z_REPEAT_O,
  // held results
  output logic      [3*miar_pkg::SAMPLE_W-1:0] AXIS_DATA_O,
  output logic      [miar_pkg::SAMPLE_W-1:0]   RES_DATA_O,
  // ready status and interrupt sources from elsewhere in the device
  input  wire logic                            READY_STATUS_I,
  input  wire logic [2:0]                      LOW_AXIS_EN_I,
  input  wire logic [2:0]                      HIGH_AXIS_EN_I,
  input  wire logic                            OTHER_INT_I,
  // pins
  output logic                                 SAMPLE_READY_PIN_O,
  output logic                                 INT_PIN_O
);
  import miar_pkg::*;

  logic [7:0]            pin_map_and_axis_enable, next_pin_map_and_axis_enable;
  logic [7:0]            low_threshold_level,     next_low_threshold_level;
  logic [7:0]            high_threshold_level,    next_high_threshold_level;
  logic [7:0]            xy_repetition_count,     next_xy_repetition_count;
  logic [7:0]            z_repetition_count,      next_z_repetition_count;
  logic [7:0]            next_rdata;
  logic [SAMPLE_W-1:0]   axis_val [3];
  logic [SAMPLE_W-1:0]   next_axis_val [3];
  logic [SAMPLE_W-1:0]   res_val, next_res_val;
  logic [2:0]            axis_on;
  logic [2:0]            low_hit;
  logic [2:0]            high_hit;
  logic                  int_cond;
  logic                  int_held, next_int_held;
  logic                  int_active;
  logic                  ready_pin, int_pin;
  logic [COUNT_W-1:0]    next_xy_cnt, next_z_cnt;
  logic                  status_read;

  // signed compare of the upper byte of a sample against a limit
  function automatic logic below_limit(input logic [SAMPLE_W-1:0] v, input logic [7:0] lim);
    below_limit = $signed(v[SAMPLE_W-1 -: 8]) < $signed(lim);
  endfunction

  function automatic logic above_limit(input logic [SAMPLE_W-1:0] v, input logic [7:0] lim);
    above_limit = $signed(v[SAMPLE_W-1 -: 8]) > $signed(lim);
  endfunction

  // channel off bits are active low enables
  assign axis_on[2] = ~pin_map_and_axis_enable[BIT_Z_OFF];
  assign axis_on[1] = ~pin_map_and_axis_enable[BIT_Y_OFF];
  assign axis_on[0] = ~pin_map_and_axis_enable[BIT_X_OFF];

  // register select indices for the one-hot decode
  localparam int SEL_PIN  = 0;
  localparam int SEL_LOW  = 1;
  localparam int SEL_HIGH = 2;
  localparam int SEL_XY   = 3;
  localparam int SEL_Z    = 4;
  localparam int SEL_STAT = 5;

  // one decode shared by the write, read and status-read paths
  function automatic logic [5:0] reg_select(input logic [6:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    case (addr)
      OFS_PIN_AXIS:   sel[SEL_PIN]  = 1'b1;
      OFS_LOW_LIMIT:  sel[SEL_LOW]  = 1'b1;
      OFS_HIGH_LIMIT: sel[SEL_HIGH] = 1'b1;
      OFS_XY_REPEAT:  sel[SEL_XY]   = 1'b1;
      OFS_Z_REPEAT:   sel[SEL_Z]    = 1'b1;
      OFS_INT_STATUS: sel[SEL_STAT] = 1'b1;
      default:        sel           = 6'h00;
    endcase
    reg_select = sel;
  endfunction

  logic [5:0] wr_sel;
  logic [5:0] rd_sel;

  assign wr_sel      = REG_WR_I ? reg_select(REG_ADDR_I) : 6'h00;
  assign rd_sel      = REG_RD_I ? reg_select(REG_ADDR_I) : 6'h00;
  assign status_read = rd_sel[SEL_STAT];

  // register writes, unmapped addresses are ignored
  always_comb begin
    next_pin_map_and_axis_enable = pin_map_and_axis_enable;
    next_low_threshold_level     = low_threshold_level;
    next_high_threshold_level    = high_threshold_level;
    next_xy_repetition_count     = xy_repetition_count;
    next_z_repetition_count      = z_repetition_count;
    if (wr_sel[SEL_PIN]) begin
      next_pin_map_and_axis_enable = REG_WDATA_I;
    end
    if (wr_sel[SEL_LOW]) begin
      next_low_threshold_level = REG_WDATA_I;
    end
    if (wr_sel[SEL_HIGH]) begin
      next_high_threshold_level = REG_WDATA_I;
    end
    if (wr_sel[SEL_XY]) begin
      next_xy_repetition_count = REG_WDATA_I;
    end
    if (wr_sel[SEL_Z]) begin
      next_z_repetition_count = REG_WDATA_I;
    end
  end

  // config registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pin_map_and_axis_enable <= RST_PIN_AXIS;
      low_threshold_level     <= RST_LOW_LIMIT;
      high_threshold_level    <= RST_HIGH_LIMIT;
      xy_repetition_count     <= RST_XY_REPEAT;
      z_repetition_count      <= RST_Z_REPEAT;
    end else begin
      pin_map_and_axis_enable <= next_pin_map_and_axis_enable;
      low_threshold_level     <= next_low_threshold_level;
      high_threshold_level    <= next_high_threshold_level;
      xy_repetition_count     <= next_xy_repetition_count;
      z_repetition_count      <= next_z_repetition_count;
    end
  end

  // read data stands for one cycle; status and unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd_sel[SEL_PIN]) begin
      next_rdata = pin_map_and_axis_enable;
    end
    if (rd_sel[SEL_LOW]) begin
      next_rdata = low_threshold_level;
    end
    if (rd_sel[SEL_HIGH]) begin
      next_rdata = high_threshold_level;
    end
    if (rd_sel[SEL_XY]) begin
      next_rdata = xy_repetition_count;
    end
    if (rd_sel[SEL_Z]) begin
      next_rdata = z_repetition_count;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end

  // per-axis result holding and limit detection
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      always_comb begin
        next_axis_val[g] = axis_val[g];
        if (SAMPLE_VALID_I[g] && axis_on[g]) begin
          next_axis_val[g] = SAMPLE_DATA_I[g*SAMPLE_W +: SAMPLE_W];
        end
      end
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          axis_val[g] <= '0;
        end else begin
          axis_val[g] <= next_axis_val[g];
        end
      end
      // held value is used even when the axis is off
      assign low_hit[g]  = LOW_AXIS_EN_I[g] && below_limit(axis_val[g], low_threshold_level);
      assign high_hit[g] = HIGH_AXIS_EN_I[g] && above_limit(axis_val[g], high_threshold_level);
      assign AXIS_DATA_O[g*SAMPLE_W +: SAMPLE_W] = axis_val[g];
    end
  endgenerate

  always_comb begin
    next_res_val = res_val;
    if (!axis_on[2]) begin
      next_res_val = '0;
    end else if (RES_VALID_I) begin
      next_res_val = RES_DATA_I;
    end
  end

  assign int_cond = (|low_hit) | (|high_hit) | OTHER_INT_I;

  // latched interrupt: a new condition wins over a status read in the same cycle
  always_comb begin
    next_int_held = int_held;
    if (status_read) begin
      next_int_held = 1'b0;
    end
    if (int_cond) begin
      next_int_held = 1'b1;
    end
    if (!pin_map_and_axis_enable[BIT_INT_LATCH]) begin
      next_int_held = 1'b0;
    end
  end

  assign int_active = pin_map_and_axis_enable[BIT_INT_LATCH] ? (int_held | int_cond) : int_cond;

  // interrupt latch register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      int_held <= 1'b0;
    end else begin
      int_held <= next_int_held;
    end
  end

  // a disabled pin rests at its deasserted level
  always_comb begin
    ready_pin = (pin_map_and_axis_enable[BIT_READY_PIN_EN] & READY_STATUS_I)
                ~^ pin_map_and_axis_enable[BIT_READY_LEVEL];
    int_pin   = (pin_map_and_axis_enable[BIT_INT_PIN_EN] & int_active)
                ~^ pin_map_and_axis_enable[BIT_INT_LEVEL];
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SAMPLE_READY_PIN_O <= 1'b0;
      INT_PIN_O          <= 1'b0;
    end else begin
      SAMPLE_READY_PIN_O <= ready_pin;
      INT_PIN_O          <= int_pin;
    end
  end

  // measurement controls toward the engine
  logic [2:0] next_axis_measure;
  logic       next_res_measure;

  always_comb begin
    next_axis_measure[2] = axis_on[2];
    next_axis_measure[1] = axis_on[1];
    next_axis_measure[0] = axis_on[0];
    next_res_measure     = axis_on[2];
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      AXIS_MEASURE_O <= 3'h7;
      RES_MEASURE_O  <= 1'b1;
    end else begin
      AXIS_MEASURE_O <= next_axis_measure;
      RES_MEASURE_O  <= next_res_measure;
    end
  end

  // repetition counts; neither sum can overflow nine bits
  always_comb begin
    next_xy_cnt = {xy_repetition_count, 1'b1};
    next_z_cnt  = {1'b0, z_repetition_count} + {{(COUNT_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      XY_REPEAT_O <= 9'h001;
      Z_REPEAT_O  <= 9'h001;
    end else begin
      XY_REPEAT_O <= next_xy_cnt;
      Z_REPEAT_O  <= next_z_cnt;
    end
  end

  // held resistance, cleared while the z channel is off
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      res_val    <= '0;
      RES_DATA_O <= '0;
    end else begin
      res_val    <= next_res_val;
      RES_DATA_O <= next_res_val;
    end
  end
endmodule
